// ==== dchan_tx.sv ====
// D-channel transmitter: APB registers, serializer, slot builder, channel mux.
// Assumes a one-cycle frame pulse at least ten clocks apart, and that the
// switch presents each output channel's connect-memory low entry in turn.
//
// Notes on behaviour
// RULE_01: software writes message bytes to a 32-byte store at one address.
// RULE_02: serial output appears as data-memory source 70 for channel muxing.
// RULE_03: control register holds irq select, rate, mode, framing, go.
// RULE_04: each frame places exactly 1, 2 or 8 bits into the slot.
// RULE_05: sending starts only once go is set and a byte is stored.
// RULE_06: bit order per byte follows a bit in the rx threshold register.
// RULE_07: message mode frames whole message with start, optional parity, stop.
// RULE_08: byte-level mode without start/stop sends raw bits only.
// RULE_09: byte-level mode with start/stop wraps every byte individually.
// RULE_10: after the last bit, rest of that frame's slot is stop bits.
// RULE_11: every channel selecting the source carries the same slot.
// RULE_12: interrupt possible on empty, three-quarters empty, or completion.
// RULE_13: with irq select high, interrupt only on completion.
// RULE_14: with irq select low, irq level picks empty or three-quarters empty.
// RULE_15: bytes written in time after empty continue message without break.
// RULE_16: byte-framed continuation allowance is 10/5/1 or 11/6/1 frames.
// RULE_17: transmitter irq enable bit gates the interrupt output.
// RULE_18: start bit is logic zero.
// RULE_19: byte mode puts start, optional parity, stop around eight bits.
// RULE_20: when idle, every slot position carries logic one.
// RULE_21: end declared when store empty and final stop, or final data bit without start/stop, sent; flags it.
//
// The APB interface to the registers is this design's own decision.

`timescale 1ns/100ps
`default_nettype none

module dchan_tx
   import dchan_tx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire apb_req_t apb,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire tdm_in_t tdm,
   output logic [7:0] chan_data,
   output logic tx_irq
);

   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] thr;
      logic [7:0] irq_enable_reg;
      logic eot;
      logic pready;
      logic [31:0] prdata;
      logic pslverr;
      ser_state_t ser;
      logic [7:0] sh;
      logic [2:0] bitcnt;
      logic par;
      logic pad;
      logic stepping;
      logic [3:0] pos;
      logic [7:0] build;
      logic [7:0] slot;
      logic [7:0] chan_data;
      logic irq;
   } tx_state_t;

   tx_state_t st_r;
   tx_state_t st_nxt;
   logic push;
   logic pop;
   logic [7:0] head;
   logic [LVL_W-1:0] level;

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Bits per frame for a rate code
   function automatic logic [3:0] rate_bits(input logic [1:0] rate);
      logic [3:0] n;
      n = BITS_8;
      if (rate == RATE_1) begin
         n = BITS_1;
      end else if (rate == RATE_2) begin
         n = BITS_2;
      end
      return n;
   endfunction

   // Next bit of a byte: order high sends the low bit first
   function automatic logic out_bit(input logic [7:0] b, input logic lsb);
      return lsb ? b[0] : b[7];
   endfunction

   // Byte after its leading bit has gone
   function automatic logic [7:0] shift_byte(input logic [7:0] b,
                                             input logic lsb);
      return lsb ? {1'b0, b[7:1]} : {b[6:0], 1'b0};
   endfunction

   // Address decode
   function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
      return (a == ADDR_FIFO_IN) || (a == ADDR_CONTROL) ||
             (a == ADDR_RX_THR) || (a == ADDR_IRQ_EN) ||
             (a == ADDR_STATUS);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Byte store
   dchan_tx_fifo u_fifo (
      .pclk(pclk),
      .presetn(presetn),
      .push(push),
      .push_data(apb.pwdata[7:0]),
      .pop(pop),
      .head(head),
      .level(level)
   );

   ////////////////////////////////////////////////////////////////////////
   // Next state of the whole block
   always_comb begin
      logic done;
      logic empty;
      logic lsb;
      logic msg;
      logic wrap_on;
      logic par_on;
      logic bit_v;
      logic eot_ev;
      logic irq_cond;
      logic [31:0] rd;
      done = 1'b0;
      empty = 1'b0;
      lsb = 1'b0;
      msg = 1'b0;
      wrap_on = 1'b0;
      par_on = 1'b0;
      bit_v = 1'b1;
      eot_ev = 1'b0;
      irq_cond = 1'b0;
      rd = '0;
      st_nxt = st_r;
      push = 1'b0;
      pop = 1'b0;
      empty = (level == '0);
      lsb = st_r.thr[THR_TX_BIT_ORDER]; // RULE_06
      msg = st_r.ctl[CTL_MSG_MODE];
      wrap_on = st_r.ctl[CTL_START_STOP];
      par_on = st_r.ctl[CTL_PARITY];
      done = apb.psel && apb.penable && st_r.pready;

      // APB access phase: one wait state, then answer
      st_nxt.pready = 1'b0;
      if (apb.psel && apb.penable && !st_r.pready) begin
         st_nxt.pready = 1'b1;
         st_nxt.pslverr = !addr_hit(apb.paddr);
         if (!apb.pwrite) begin
            unique case (apb.paddr)
               ADDR_CONTROL: rd[7:0] = st_r.ctl;
               ADDR_RX_THR: rd[7:0] = st_r.thr;
               ADDR_IRQ_EN: rd[7:0] = st_r.irq_enable_reg;
               ADDR_STATUS: begin
                  rd[STAT_EOT] = st_r.eot;
                  rd[STAT_BUSY] = (st_r.ser != S_IDLE);
                  rd[STAT_LVL_LO +: LVL_W] = level;
               end
               default: rd = '0;
            endcase
         end
         st_nxt.prdata = rd;
      end

      // Software clear of the end flag comes before the hardware set
      if (done && apb.pwrite && (apb.paddr == ADDR_STATUS) &&
          apb.pwdata[STAT_EOT]) begin
         st_nxt.eot = 1'b0;
      end

      // Frame start: publish last slot, begin a fresh one of all ones
      if (tdm.frame_start) begin
         st_nxt.slot = st_r.build;
         st_nxt.build = IDLE_SLOT; // RULE_20
         st_nxt.pos = '0;
         st_nxt.pad = 1'b0;
         st_nxt.stepping = 1'b1;
      end else if (st_r.stepping) begin
         st_nxt.pos = st_r.pos + 4'd1;
         if (st_r.pos == LAST_POS) begin
            st_nxt.stepping = 1'b0;
         end
         // Only the programmed number of positions carry bits
         if ((st_r.pos < rate_bits(st_r.ctl[CTL_RATE_HI:CTL_RATE_LO])) &&
             !st_r.pad) begin // RULE_04 RULE_10
            unique case (st_r.ser)
               S_IDLE: begin
                  if (st_r.ctl[CTL_GO] && !empty) begin // RULE_05
                     pop = 1'b1;
                     st_nxt.par = 1'b0;
                     st_nxt.ser = S_DATA;
                     if (msg || wrap_on) begin
                        bit_v = 1'b0; // RULE_18 RULE_07 RULE_19
                        st_nxt.sh = head;
                        st_nxt.bitcnt = '0;
                     end else begin
                        bit_v = out_bit(head, lsb); // RULE_08
                        st_nxt.sh = shift_byte(head, lsb);
                        st_nxt.bitcnt = 3'd1;
                     end
                  end
               end
               S_DATA: begin
                  bit_v = out_bit(st_r.sh, lsb);
                  st_nxt.par = st_r.par ^ bit_v;
                  st_nxt.sh = shift_byte(st_r.sh, lsb);
                  st_nxt.bitcnt = st_r.bitcnt + 3'd1;
                  if (st_r.bitcnt == LAST_BIT) begin
                     if (msg) begin
                        // Message continues while bytes keep coming
                        if (!empty) begin // RULE_15
                           pop = 1'b1;
                           st_nxt.sh = head;
                           st_nxt.bitcnt = '0;
                        end else begin
                           st_nxt.ser = par_on ? S_PARITY : S_STOP; // RULE_07
                        end
                     end else if (wrap_on) begin
                        st_nxt.ser = par_on ? S_PARITY : S_STOP; // RULE_09
                     end else if (!empty) begin
                        pop = 1'b1; // RULE_15
                        st_nxt.sh = head;
                        st_nxt.bitcnt = '0;
                     end else begin
                        st_nxt.ser = S_IDLE; // RULE_08
                        eot_ev = 1'b1;
                     end
                  end
               end
               S_PARITY: begin
                  bit_v = st_r.par; // RULE_09
                  st_nxt.ser = S_STOP;
               end
               S_STOP: begin
                  bit_v = 1'b1; // RULE_19
                  st_nxt.ser = S_IDLE; // RULE_16
                  if (msg || empty) begin
                     eot_ev = 1'b1; // RULE_21
                  end
               end
            endcase
            st_nxt.build[3'(LAST_POS - st_r.pos)] = bit_v;
         end
      end

      // End of transmission: flag, stop, pad out the slot
      if (eot_ev) begin
         st_nxt.eot = 1'b1; // RULE_21
         st_nxt.ctl[CTL_GO] = 1'b0;
         st_nxt.pad = 1'b1; // RULE_10
      end

      // Register writes after the engine so a software go wins
      if (done && apb.pwrite) begin
         unique case (apb.paddr)
            ADDR_FIFO_IN: push = 1'b1; // RULE_01
            ADDR_CONTROL: st_nxt.ctl = apb.pwdata[7:0]; // RULE_03
            ADDR_RX_THR: st_nxt.thr = apb.pwdata[7:0];
            ADDR_IRQ_EN: st_nxt.irq_enable_reg = apb.pwdata[7:0];
            default: st_nxt.eot = st_nxt.eot;
         endcase
      end

      // Interrupt condition and enable gate
      if (st_r.ctl[CTL_IRQ_SELECT]) begin
         irq_cond = st_r.eot; // RULE_13
      end else if (st_r.ctl[CTL_IRQ_LEVEL]) begin
         irq_cond = (level <= LVL_QUARTER); // RULE_14 RULE_12
      end else begin
         irq_cond = empty; // RULE_14 RULE_12
      end
      st_nxt.irq = irq_cond && st_r.irq_enable_reg[IRQ_ENABLE_REG_TX]; // RULE_17

      // Channel mux: the source may feed any number of channels
      if (tdm.cm_low == DM_TX_SOURCE) begin
         st_nxt.chan_data = st_r.slot; // RULE_02 RULE_11
      end else begin
         st_nxt.chan_data = tdm.dm_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
         st_r.ctl <= CTL_RST;
         st_r.thr <= THR_RST;
         st_r.irq_enable_reg <= IRQ_ENABLE_REG_RST;
         st_r.ser <= S_IDLE;
         st_r.build <= IDLE_SLOT;
         st_r.slot <= IDLE_SLOT;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs straight from flops
   assign pready = st_r.pready;
   assign prdata = st_r.prdata;
   assign pslverr = st_r.pslverr;
   assign chan_data = st_r.chan_data;
   assign tx_irq = st_r.irq;

endmodule

`default_nettype wire

// ==== dchan_tx_chk.sv ====
// Concurrent checks on the transmitter's APB and channel ports.
// Assumes one pclk domain and an active-low asynchronous presetn.
`timescale 1ns/100ps
`default_nettype none

module dchan_tx_chk
   import dchan_tx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire apb_req_t apb,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire tdm_in_t tdm,
   input wire logic [7:0] chan_data,
   input wire logic tx_irq
);
   logic en_r;
   logic mapped;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // Addresses that decode to a register
   assign mapped = apb.paddr inside {ADDR_FIFO_IN, ADDR_CONTROL,
      ADDR_RX_THR, ADDR_IRQ_EN, ADDR_STATUS};

   // Mirror of the transmitter irq enable bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         en_r <= 1'b0;
      else if (apb.psel && apb.penable && pready && apb.pwrite &&
               apb.paddr == ADDR_IRQ_EN)
         en_r <= apb.pwdata[IRQ_ENABLE_REG_TX];
   end

   ////////////////////////////////////////
   sequence access_wait_s;
      apb.psel && apb.penable && !pready;
   endsequence
   sequence source_twice_s;
      tdm.cm_low == DM_TX_SOURCE && !tdm.frame_start ##1
      tdm.cm_low == DM_TX_SOURCE && !tdm.frame_start;
   endsequence

   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready high for more than one cycle");
   wait_state_a: assert property (access_wait_s |=> pready)
      else $error("access phase not answered after one wait");
   answer_cause_a: assert property (pready |-> $past(apb.psel && apb.penable))
      else $error("pready without a pending access");
   unmapped_err_a: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not match address decode");
   store_read_a: assert property (pready && !apb.pwrite &&
      apb.paddr == ADDR_FIFO_IN |-> prdata == '0)
      else $error("store input port read not zero");
   data_hold_a: assert property (!pready |-> $stable(prdata))
      else $error("prdata changed outside an answer");
   mux_pass_a: assert property (tdm.cm_low != DM_TX_SOURCE |=>
      chan_data == $past(tdm.dm_data))
      else $error("unselected channel lost its data byte");
   broadcast_a: assert property (source_twice_s |=> $stable(chan_data))
      else $error("selected channels differ within a frame");
   irq_gate_a: assert property (!en_r && !$past(en_r) |-> !tx_irq)
      else $error("interrupt raised while disabled");
endmodule

bind dchan_tx dchan_tx_chk chk_i (
   .pclk(pclk),
   .presetn(presetn),
   .apb(apb),
   .pready(pready),
   .prdata(prdata),
   .pslverr(pslverr),
   .tdm(tdm),
   .chan_data(chan_data),
   .tx_irq(tx_irq)
);
`default_nettype wire

// ==== dchan_tx_fifo.sv ====
// Transmit byte store of the D-channel transmitter.
// Assumes the caller never pops when empty; pushes into a full store drop unless a pop comes in the same cycle.

`timescale 1ns/100ps
`default_nettype none

module dchan_tx_fifo
   import dchan_tx_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic push,
   input wire logic [7:0] push_data,
   input wire logic pop,
   output logic [7:0] head,
   output logic [LVL_W-1:0] level
);

   typedef struct packed {
      logic [FIFO_DEPTH-1:0][7:0] mem;
      logic [FIFO_AW-1:0] wr;
      logic [FIFO_AW-1:0] rd;
      logic [LVL_W-1:0] level;
   } fifo_state_t;

   fifo_state_t st_r;
   fifo_state_t st_nxt;
   logic do_push;
   logic do_pop;

   ////////////////////////////////////////////////////////////////////////
   // Next state: pointers and fill level
   always_comb begin
      st_nxt = st_r;
      do_pop = pop && (st_r.level != '0);
      do_push = push && ((st_r.level != LVL_FULL) || do_pop); // RULE_01
      if (do_push) begin
         st_nxt.mem[st_r.wr] = push_data;
         st_nxt.wr = st_r.wr + 5'd1;
      end
      if (do_pop) begin
         st_nxt.rd = st_r.rd + 5'd1;
      end
      if (do_push && !do_pop) begin
         st_nxt.level = st_r.level + 6'd1;
      end else if (do_pop && !do_push) begin
         st_nxt.level = st_r.level - 6'd1;
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign head = st_r.mem[st_r.rd];
   assign level = st_r.level;

endmodule

`default_nettype wire

// ==== dchan_tx_pkg.sv ====
// Constants, register map and carrier types of the D-channel transmitter.
// Assumes a 32-bit APB master and a frame pulse from the switch timing.

package dchan_tx_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Register indices on the control page, byte address is index times four
   localparam logic [7:0] REGNUM_FIFO_IN = 8'h44;
   localparam logic [7:0] REGNUM_CONTROL = 8'h45;
   localparam logic [7:0] REGNUM_RX_THR = 8'h48;
   localparam logic [7:0] REGNUM_IRQ_EN = 8'h49;
   localparam logic [7:0] REGNUM_STATUS = 8'h4A;
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_FIFO_IN = {2'b00, REGNUM_FIFO_IN, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = {2'b00, REGNUM_CONTROL, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_RX_THR = {2'b00, REGNUM_RX_THR, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = {2'b00, REGNUM_IRQ_EN, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS = {2'b00, REGNUM_STATUS, 2'b00};

   ////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int CTL_IRQ_SELECT = 7;
   localparam int CTL_IRQ_LEVEL = 6;
   localparam int CTL_RATE_HI = 5;
   localparam int CTL_RATE_LO = 4;
   localparam int CTL_MSG_MODE = 3;
   localparam int CTL_START_STOP = 2;
   localparam int CTL_PARITY = 1;
   localparam int CTL_GO = 0;
   localparam logic [1:0] RATE_1 = 2'b00;
   localparam logic [1:0] RATE_2 = 2'b01;
   localparam logic [3:0] BITS_1 = 4'h1;
   localparam logic [3:0] BITS_2 = 4'h2;
   localparam logic [3:0] BITS_8 = 4'h8;

   // Other fields
   localparam int THR_TX_BIT_ORDER = 7;
   localparam int IRQ_ENABLE_REG_TX = 0;
   localparam int STAT_EOT = 0;
   localparam int STAT_BUSY = 1;
   localparam int STAT_LVL_LO = 8;

   // Reset values
   localparam logic [7:0] CTL_RST = 8'h00;
   localparam logic [7:0] THR_RST = 8'h00;
   localparam logic [7:0] IRQ_ENABLE_REG_RST = 8'h00;
   localparam logic [7:0] IDLE_SLOT = 8'hFF;

   ////////////////////////////////////////////////////////////////////////
   // Storage and TDM constants
   localparam int FIFO_DEPTH = 32;
   localparam int FIFO_AW = 5;
   localparam int LVL_W = 6;
   localparam logic [LVL_W-1:0] LVL_FULL = 6'h20;
   localparam logic [LVL_W-1:0] LVL_QUARTER = 6'h08;
   localparam logic [7:0] DM_TX_SOURCE = 8'h70;
   localparam logic [3:0] LAST_POS = 4'h7;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // Serializer states
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_DATA = 2'b01,
      S_PARITY = 2'b10,
      S_STOP = 2'b11
   } ser_state_t;

   // APB request from the master
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } apb_req_t;

   // Switch side inputs for the channel now being assembled
   typedef struct packed {
      logic frame_start;
      logic [7:0] cm_low;
      logic [7:0] dm_data;
   } tdm_in_t;

endpackage

// ==== tb.sv ====
// Self-checking bench for the transmitter: reset values, rows of framing cases,
// then store fill, interrupt modes and a second reset.
`timescale 1ns/100ps
`default_nettype none

module tb
   import dchan_tx_pkg::*;
;
   typedef struct packed {
      logic [7:0] ctl;
      logic [7:0] thr;
      logic [7:0] d0;
      logic [7:0] d1;
   } row_t;
   localparam row_t rows [6] = '{'{8'h29, 8'h00, 8'hA5, 8'h3C},
      '{8'h0F, 8'h80, 8'h5A, 8'hC3}, '{8'h13, 8'h00, 8'h3C, 8'h81},
      '{8'h25, 8'h00, 8'hF0, 8'h0F}, '{8'h17, 8'h80, 8'h81, 8'h7E},
      '{8'h3B, 8'h00, 8'h00, 8'hFF}};
   localparam logic [31:0] one_w = 32'h0000_0001;
   logic pclk, presetn, pready, pslverr, tx_irq, erv, fdone;
   logic [31:0] prdata, v;
   logic [7:0] chan_data, e;
   logic [3:0] sel;
   logic [3:0][7:0] rx;
   apb_req_t apb;
   tdm_in_t tdm;
   logic bq[$];
   int nb, bit_i, n, err_total, tests_run;

   dchan_tx DUT (.pclk(pclk), .presetn(presetn), .apb(apb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .tdm(tdm),
      .chan_data(chan_data), .tx_irq(tx_irq));
   tdm_chan_model #(.FRAME(16)) link (.pclk(pclk), .presetn(presetn),
      .sel_mask(sel), .chan_data(chan_data), .tdm(tdm), .rx_slot(rx),
      .frame_done(fdone));

   // Clock of 100 ns
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   ////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bounded wait on the frame end or on an irq level
   task automatic wait_for(input bit frame, input logic lv);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while ((frame ? fdone : tx_irq) !== (frame | lv) && n < 2000);
      if (n >= 2000) begin
         err_total++;
         stop_test();
      end
   endtask
   // One APB transfer launched at the next rising edge
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [7:0] d);
      @(posedge pclk);
      apb <= '{1'b1, 1'b0, w, a, 32'(d)};
      @(posedge pclk);
      apb.penable <= 1'b1;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         err_total++;
         stop_test();
      end
      v = prdata;
      erv = pslverr;
      @(posedge pclk);
      apb <= '0;
   endtask
   // Line bits of one two-byte case
   task automatic build(input row_t r);
      logic [7:0] d;
      logic m;
      logic y;
      logic p;
      m = r.ctl[CTL_MSG_MODE];
      y = r.ctl[CTL_START_STOP] && !m;
      p = r.ctl[CTL_PARITY];
      nb = (r.ctl[5:4] == RATE_1) ? 1 : (r.ctl[5:4] == RATE_2) ? 2 : 8;
      bq.delete();
      if (m)
         bq.push_back(1'b0);
      for (int k = 0; k < 2; k++) begin
         d = (k == 1) ? r.d1 : r.d0;
         if (y)
            bq.push_back(1'b0);
         for (int i = 0; i < 8; i++)
            bq.push_back(r.thr[THR_TX_BIT_ORDER] ? d[i] : d[7 - i]);
         if (y && p)
            bq.push_back(^d);
         if (y)
            bq.push_back(1'b1);
      end
      if (m && p)
         bq.push_back(^(r.d0 ^ r.d1));
      if (m)
         bq.push_back(1'b1);
   endtask

   ////////////////////////////////////////
   initial begin
      apb = '0;
      presetn = 1'b0;
      sel = 4'b0011;
      err_total = 0;
      tests_run = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, unmapped place, control read back
      xfer(1'b0, ADDR_CONTROL, 8'h00);
      chk(v, 32'(CTL_RST));
      xfer(1'b0, ADDR_RX_THR, 8'h00);
      chk(v, 32'(THR_RST));
      xfer(1'b0, ADDR_STATUS, 8'h00);
      chk(v, '0);
      xfer(1'b0, 12'hFFC, 8'h00);
      chk({v[30:0], erv}, one_w);
      xfer(1'b1, ADDR_CONTROL, 8'hE8);
      xfer(1'b0, ADDR_CONTROL, 8'h00);
      chk(v, 32'h0000_00E8);
      // Framing cases
      foreach (rows[i]) begin
         xfer(1'b1, ADDR_RX_THR, rows[i].thr);
         xfer(1'b1, ADDR_CONTROL, rows[i].ctl);
         build(rows[i]);
         wait_for(1'b1, 1'b1);
         // First byte lands after the stepping window of this frame
         repeat (7) @(posedge pclk);
         xfer(1'b1, ADDR_FIFO_IN, rows[i].d0);
         xfer(1'b1, ADDR_FIFO_IN, rows[i].d1);
         bit_i = 0;
         do
            wait_for(1'b1, 1'b1);
         while (rx[0] === IDLE_SLOT && ++bit_i < 4);
         bit_i = 0;
         while (bit_i < bq.size()) begin
            e = IDLE_SLOT;
            for (int j = 0; j < nb; j++) begin
               if (bit_i < bq.size())
                  e[7 - j] = bq[bit_i];
               bit_i++;
            end
            chk(32'(rx[0]), 32'(e));
            chk(32'(rx[1]), 32'(e));
            chk(32'(rx[2]), 32'h0000_00C2);
            wait_for(1'b1, 1'b1);
         end
         chk(32'(rx[0]), 32'(IDLE_SLOT));
         xfer(1'b0, ADDR_STATUS, 8'h00);
         chk(32'(v[STAT_EOT]), one_w);
         xfer(1'b0, ADDR_CONTROL, 8'h00);
         chk(32'(v[CTL_GO]), '0);
         xfer(1'b1, ADDR_STATUS, 8'h01);
      end
      // Fill past full without go, then three-quarters interrupt
      xfer(1'b1, ADDR_CONTROL, 8'h60);
      xfer(1'b1, ADDR_IRQ_EN, 8'h01);
      for (int k = 0; k < 33; k++)
         xfer(1'b1, ADDR_FIFO_IN, 8'(k));
      wait_for(1'b1, 1'b1);
      wait_for(1'b1, 1'b1);
      chk(32'(rx[0]), 32'(IDLE_SLOT));
      xfer(1'b0, ADDR_STATUS, 8'h00);
      chk(32'(v[STAT_LVL_LO +: LVL_W]), 32'(LVL_FULL));
      chk(32'(tx_irq), '0);
      xfer(1'b1, ADDR_CONTROL, 8'h69);
      wait_for(1'b0, 1'b1);
      xfer(1'b0, ADDR_STATUS, 8'h00);
      chk(32'(v[STAT_LVL_LO +: LVL_W] <= LVL_QUARTER), one_w);
      // Empty level, then end of transmission only
      xfer(1'b1, ADDR_CONTROL, 8'h29);
      repeat (2) @(posedge pclk);
      chk(32'(tx_irq), '0);
      wait_for(1'b0, 1'b1);
      xfer(1'b0, ADDR_STATUS, 8'h00);
      chk(32'(v[STAT_LVL_LO +: LVL_W]), '0);
      // Let the message end, clear its flag, then send one more byte
      repeat (3) wait_for(1'b1, 1'b1);
      xfer(1'b1, ADDR_STATUS, 8'h01);
      xfer(1'b1, ADDR_CONTROL, 8'hA9);
      repeat (2) @(posedge pclk);
      chk(32'(tx_irq), '0);
      xfer(1'b1, ADDR_FIFO_IN, 8'h5A);
      wait_for(1'b0, 1'b1);
      xfer(1'b0, ADDR_STATUS, 8'h00);
      chk(32'(v[STAT_EOT]), one_w);
      xfer(1'b1, ADDR_IRQ_EN, 8'h00);
      repeat (2) @(posedge pclk);
      chk(32'(tx_irq), '0);
      xfer(1'b1, ADDR_IRQ_EN, 8'h01);
      repeat (2) @(posedge pclk);
      chk(32'(tx_irq), one_w);
      xfer(1'b1, ADDR_STATUS, 8'h01);
      repeat (2) @(posedge pclk);
      chk(32'(tx_irq), '0);
      // Second reset in mid-run
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, ADDR_IRQ_EN, 8'h00);
      chk(v, 32'(IRQ_ENABLE_REG_RST));
      stop_test();
   end
endmodule
`default_nettype wire

// ==== tdm_chan_model.sv ====
// Switch side model: frame pulse, four output channels, slot capture.
// Assumes FRAME of at least 16 clocks; channels sit at positions 10..13.
`timescale 1ns/100ps
`default_nettype none

module tdm_chan_model
   import dchan_tx_pkg::*;
#(parameter int FRAME = 16)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [3:0] sel_mask,
   input wire logic [7:0] chan_data,
   output tdm_in_t tdm,
   output logic [3:0][7:0] rx_slot,
   output logic frame_done
);
   logic [4:0] pos;
   logic [4:0] ch;

   // Frame position and capture of each channel's byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pos <= '0;
         rx_slot <= '0;
      end else begin
         pos <= (pos == 5'(FRAME - 1)) ? '0 : pos + 5'd1;
         if (pos >= 5'd11 && pos <= 5'd14)
            rx_slot[2'(pos - 5'd11)] <= chan_data;
      end
   end

   // Connect memory entries per channel, moving filler elsewhere
   assign ch = pos - 5'd10;
   assign frame_done = pos == 5'(FRAME - 1);
   always_comb begin
      tdm.frame_start = pos == '0;
      tdm.cm_low = 8'h00;
      tdm.dm_data = ~{3'b000, pos};
      if (ch < 5'd4) begin
         tdm.cm_low = sel_mask[2'(ch)] ? DM_TX_SOURCE : 8'h00;
         tdm.dm_data = {6'h30, 2'(ch)};
      end
   end
endmodule
`default_nettype wire
